// ==== io_port_map.svh ====
// io port constants: sizes, pin groups, reset values
`ifndef IO_PORT_MAP_SVH
`define IO_PORT_MAP_SVH

// ----------------------------------------------------------------------
// port geometry
// ----------------------------------------------------------------------
`define PORT_PINS      8
`define PAIR_COUNT     2
`define SPECIAL_BASE   4
`define SPECIAL_MASK   8'hF0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_CFG_INIT   2'h0
`define PIN_BITS_INIT  8'h00
`define PHASE_INIT     2'h0

`endif

// ==== io_port_pkg.sv ====
// types of the io port controller
`include "io_port_map.svh"

package io_port_pkg;

    // ------------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        DM_HIZ_ANALOG  = 3'b000,
        DM_HIZ_DIGITAL = 3'b001,
        DM_RES_UP      = 3'b010,
        DM_RES_DOWN    = 3'b011,
        DM_OD_LOW      = 3'b100,
        DM_OD_HIGH     = 3'b101,
        DM_STRONG      = 3'b110,
        DM_RES_BOTH    = 3'b111
    } drive_mode_t;

    typedef enum logic [1:0] {
        RST_HIZ       = 2'b00,
        RST_PULL_DOWN = 2'b01,
        RST_PULL_UP   = 2'b10
    } rst_cfg_t;

    typedef enum logic [1:0] {
        CONN_NONE   = 2'b00,
        CONN_GLOBAL = 2'b01,
        CONN_MUX    = 2'b10
    } conn_t;

    typedef enum logic [1:0] {
        THR_HALF_SUPPLY = 2'b00,
        THR_FORTY_SUPPLY = 2'b01,
        THR_HALF_REF    = 2'b10,
        THR_FULL_REF    = 2'b11
    } thr_t;

    typedef enum logic [1:0] {
        EDGE_NONE = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } edge_t;

    typedef enum logic [1:0] {
        PH_LOAD  = 2'b00,
        PH_RUN   = 2'b01,
        PH_SLEEP = 2'b10
    } phase_t;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        drive_mode_t mode;
        logic        data;
        logic        in_dis;
        conn_t       conn;
        logic [2:0]  bus_idx;
        logic        reg_out;
        edge_t       irq_edge;
    } pin_cfg_t;

    typedef struct packed {
        thr_t thr;
        logic diff_en;
        logic cmp_en;
        logic hyst_en;
    } pair_cfg_t;

    typedef struct packed {
        logic       strong_hi;
        logic       strong_lo;
        logic       res_hi;
        logic       res_lo;
        logic       in_en;
        logic       reg_lvl;
        conn_t      conn;
        logic [2:0] bus_idx;
    } pad_ctl_t;

    typedef struct packed {
        logic use_diff;
        logic use_analog;
        thr_t thr;
        logic hyst_en;
    } ref_ctl_t;

    typedef edge_t [`PORT_PINS-1:0] edge_vec_t;

    // ------------------------------------------------------------------
    // module state
    // ------------------------------------------------------------------
    typedef struct packed {
        phase_t                          phase;
        rst_cfg_t                        rst_cfg;
        logic [`PORT_PINS-1:0]           cfg_set;
        pin_cfg_t [`PORT_PINS-1:0]       cfg;
        pair_cfg_t [`PAIR_COUNT-1:0]     pair;
        logic [`PORT_PINS-1:0]           sync1;
        logic [`PORT_PINS-1:0]           sync2;
        pad_ctl_t [`PORT_PINS-1:0]       pad;
        logic [`PORT_PINS-1:0]           din;
        ref_ctl_t [`PAIR_COUNT-1:0]      refc;
        logic [`PORT_PINS-1:0]           reject;
    } ctrl_state_t;

    typedef struct packed {
        logic                  primed;
        logic [`PORT_PINS-1:0] prev;
        logic [`PORT_PINS-1:0] status;
    } irq_state_t;

endpackage

// ==== port_irq_unit.sv ====
// pin interrupt unit: per-pin edge detect into sticky status bits
`timescale 1ns/10ps
`include "io_port_map.svh"

module port_irq_unit (
    // clock, reset, enable
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  ce,
    // sampled pin levels and edge selection
    input  wire logic [`PORT_PINS-1:0] level,
    input  io_port_pkg::edge_vec_t     edge_sel,
    // status clear and results
    input  wire logic [`PORT_PINS-1:0] clr,
    output logic [`PORT_PINS-1:0]      status,
    output logic                       any
);
    import io_port_pkg::*;

    irq_state_t s_q;
    irq_state_t s_d;

    // ------------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------------
    // ungated: runs in every power phase
    always_comb begin
        logic [`PORT_PINS-1:0] hit;
        hit = `PIN_BITS_INIT;
        s_d = s_q;
        s_d.primed = 1'b1;
        s_d.prev = level;
        for (int i = 0; i < `PORT_PINS; i++) begin
            case (edge_sel[i])
                EDGE_RISE: hit[i] = level[i] & ~s_q.prev[i];
                EDGE_FALL: hit[i] = ~level[i] & s_q.prev[i];
                EDGE_BOTH: hit[i] = level[i] ^ s_q.prev[i];
                default:   hit[i] = 1'b0;
            endcase
        end
        // no history after reset, so no edge yet
        if (!s_q.primed) begin
            hit = `PIN_BITS_INIT;
        end
        // an event in the clearing cycle wins
        s_d.status = (s_q.status & ~clr) | hit;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign status = s_q.status;
    assign any    = |s_q.status;

endmodule

// ==== io_port_ctrl.sv ====
// io port controller: reset state, drive decode, special pin options
`timescale 1ns/10ps
`include "io_port_map.svh"

module io_port_ctrl (
    // clock, reset, enable
    input  wire logic                                  clk,
    input  wire logic                                  rst,
    input  wire logic                                  ce,

    // nonvolatile reset setting and its rewrite
    input  io_port_pkg::rst_cfg_t                      nv_rst_cfg,
    input  wire logic                                  rst_cfg_wr,
    input  io_port_pkg::rst_cfg_t                      rst_cfg_wdata,

    // pin configuration writes
    input  wire logic [`PORT_PINS-1:0]                 cfg_wr,
    input  io_port_pkg::pin_cfg_t                      cfg_wdata,

    // pair configuration writes
    input  wire logic [`PAIR_COUNT-1:0]                pair_wr,
    input  io_port_pkg::pair_cfg_t                     pair_wdata,

    // power state
    input  wire logic                                  low_power,

    // pin interrupts
    input  wire logic [`PORT_PINS-1:0]                 irq_clr,
    output logic [`PORT_PINS-1:0]                      irq_status,
    output logic                                       irq_req,
    output logic                                       wake_req,

    // pad side
    input  wire logic [`PORT_PINS-1:0]                 pin_in,
    output io_port_pkg::pad_ctl_t [`PORT_PINS-1:0]     pad_ctl,
    output io_port_pkg::ref_ctl_t [`PAIR_COUNT-1:0]    ref_ctl,
    output logic [`PORT_PINS-1:0]                      pin_data,

    // status
    output logic [`PORT_PINS-1:0]                      cfg_reject,
    output io_port_pkg::rst_cfg_t                      rst_cfg,
    output io_port_pkg::phase_t                        phase
);
    import io_port_pkg::*;

    localparam logic [`PORT_PINS-1:0] SPECIAL = `SPECIAL_MASK;

    ctrl_state_t s_q;
    ctrl_state_t s_d;
    edge_vec_t   edge_sel;
    logic        irq_any;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // resistive modes, barred on a regulated level
    function automatic logic is_resistive(input drive_mode_t m);
        logic r;

        r = (m == DM_RES_UP) || (m == DM_RES_DOWN) || (m == DM_RES_BOTH);
        return r;
    endfunction

    // drive mode and data bit to pad legs
    function automatic pad_ctl_t decode_pad(input pin_cfg_t c,
                                            input logic     special);
        pad_ctl_t p;
        p = '0;

        case (c.mode)
            DM_HIZ_ANALOG: begin
                p.in_en = 1'b0;
            end

            DM_HIZ_DIGITAL: begin
                p.in_en = 1'b1;
            end

            DM_RES_UP: begin
                p.res_hi    = c.data;
                p.strong_lo = ~c.data;
            end

            DM_RES_DOWN: begin
                p.strong_hi = c.data;
                p.res_lo    = ~c.data;
            end

            DM_OD_LOW: begin
                p.strong_lo = ~c.data;
            end

            DM_OD_HIGH: begin
                p.strong_hi = c.data;
            end

            DM_STRONG: begin
                p.strong_hi = c.data;
                p.strong_lo = ~c.data;
            end

            DM_RES_BOTH: begin
                p.res_hi = c.data;
                p.res_lo = ~c.data;
            end

            default: begin
                p = '0;
            end
        endcase

        // input buffer can be switched off in any mode but analog
        if (c.mode != DM_HIZ_ANALOG) begin
            p.in_en = ~c.in_dis;
        end

        // regulated level exists only on special pins
        p.reg_lvl = special & c.reg_out;

        // analog buses reach general pins only, one bus at a time
        if (!special && (c.conn == CONN_GLOBAL || c.conn == CONN_MUX)) begin
            p.conn    = c.conn;
            p.bus_idx = c.bus_idx;
        end else begin
            p.conn    = CONN_NONE;
            p.bus_idx = 3'h0;
        end
        return p;
    endfunction

    // reset pad state of pins never written
    function automatic pad_ctl_t reset_pad(input rst_cfg_t r);
        pad_ctl_t p;
        p = '0;

        case (r)
            RST_PULL_UP: begin
                p.res_hi = 1'b1;
                p.in_en  = 1'b1;
            end

            RST_PULL_DOWN: begin
                p.res_lo = 1'b1;
                p.in_en  = 1'b1;
            end

            default: begin
                p = '0;
            end
        endcase
        return p;
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        pin_cfg_t c;
        c   = '0;
        s_d = s_q;

        // two-flop pad synchroniser
        s_d.sync1 = pin_in;
        s_d.sync2 = s_q.sync1;

        // phase sequence and software writes
        case (s_q.phase)
            PH_LOAD: begin
                s_d.rst_cfg = nv_rst_cfg;
                s_d.phase   = PH_RUN;
            end

            PH_RUN: begin
                if (low_power) begin
                    s_d.phase = PH_SLEEP;
                end else begin
                    if (rst_cfg_wr) begin
                        s_d.rst_cfg = rst_cfg_wdata;
                    end
                    for (int i = 0; i < `PORT_PINS; i++) begin
                        if (cfg_wr[i]) begin
                            s_d.cfg[i]     = cfg_wdata;
                            s_d.cfg_set[i] = 1'b1;
                        end
                    end
                    for (int k = 0; k < `PAIR_COUNT; k++) begin
                        if (pair_wr[k]) begin
                            s_d.pair[k] = pair_wdata;
                        end
                    end
                end
            end

            PH_SLEEP: begin
                // writes are dropped here so nothing can move a pin
                if (!low_power) begin
                    s_d.phase = PH_RUN;
                end
            end

            default: begin
                s_d.phase = PH_LOAD;
            end
        endcase

        // pads follow the config only while running
        if (s_q.phase == PH_RUN && !low_power) begin
            for (int i = 0; i < `PORT_PINS; i++) begin
                c = s_q.cfg[i];
                s_d.reject[i] = 1'b0;
                if (SPECIAL[i] && c.reg_out && is_resistive(c.mode)) begin
                    c.mode        = DM_HIZ_DIGITAL;
                    s_d.reject[i] = 1'b1;
                end
                if (!SPECIAL[i] && c.conn != CONN_NONE &&
                    c.conn != CONN_GLOBAL && c.conn != CONN_MUX) begin
                    s_d.reject[i] = 1'b1;
                end
                if (s_q.cfg_set[i]) begin
                    s_d.pad[i] = decode_pad(c, SPECIAL[i]);
                end else begin
                    s_d.pad[i] = reset_pad(s_q.rst_cfg);
                end
            end

            // shared reference generator, one per pair
            for (int k = 0; k < `PAIR_COUNT; k++) begin
                s_d.refc[k].use_diff   = s_q.pair[k].diff_en |
                                         s_q.pair[k].cmp_en;
                s_d.refc[k].use_analog = s_q.pair[k].cmp_en;
                s_d.refc[k].thr        = s_q.pair[k].thr;
                s_d.refc[k].hyst_en    = s_q.pair[k].hyst_en;
            end
        end

        // inputs sampled in every phase for wake
        for (int i = 0; i < `PORT_PINS; i++) begin
            s_d.din[i] = s_q.sync2[i] & s_q.pad[i].in_en;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // all-zero pads are hi-z analog for the whole reset
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q         <= '0;
            s_q.phase   <= phase_t'(`PHASE_INIT);
            s_q.rst_cfg <= rst_cfg_t'(`RST_CFG_INIT);
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // pin interrupts
    // ------------------------------------------------------------------
    // unwritten pins select no edge
    always_comb begin
        for (int i = 0; i < `PORT_PINS; i++) begin
            edge_sel[i] = s_q.cfg_set[i] ? s_q.cfg[i].irq_edge : EDGE_NONE;
        end
    end

    port_irq_unit u_irq (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .level    (s_q.din),
        .edge_sel (edge_sel),
        .clr      (irq_clr),
        .status   (irq_status),
        .any      (irq_any)
    );

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign irq_req    = irq_any;
    assign wake_req   = irq_any && (s_q.phase == PH_SLEEP);
    assign pad_ctl    = s_q.pad;
    assign ref_ctl    = s_q.refc;
    assign pin_data   = s_q.din;
    assign cfg_reject = s_q.reject;
    assign rst_cfg    = s_q.rst_cfg;
    assign phase      = s_q.phase;

endmodule

// ==== io_port_checker_asserts.sv ====
// checker for the io port controller, bound to its ports
`timescale 1ns/10ps
`include "io_port_map.svh"

module io_port_checker
    import io_port_pkg::*;
(
    // clock, reset, enable
    input wire logic                               clk,
    input wire logic                               rst,
    input wire logic                               ce,
    // writes and power
    input io_port_pkg::rst_cfg_t                   nv_rst_cfg,
    input wire logic [`PORT_PINS-1:0]              cfg_wr,
    input io_port_pkg::pin_cfg_t                   cfg_wdata,
    input wire logic [`PAIR_COUNT-1:0]             pair_wr,
    input io_port_pkg::pair_cfg_t                  pair_wdata,
    input wire logic                               low_power,
    // interrupts
    input wire logic [`PORT_PINS-1:0]              irq_clr,
    input wire logic [`PORT_PINS-1:0]              irq_status,
    input wire logic                               irq_req,
    input wire logic                               wake_req,
    // pad side and status
    input io_port_pkg::pad_ctl_t [`PORT_PINS-1:0]  pad_ctl,
    input io_port_pkg::ref_ctl_t [`PAIR_COUNT-1:0] ref_ctl,
    input wire logic [`PORT_PINS-1:0]              cfg_reject,
    input io_port_pkg::rst_cfg_t                   rst_cfg,
    input io_port_pkg::phase_t                     phase
);
    logic                  bad_reg;
    logic [`PORT_PINS-1:0] keep_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // a regulated special pin showing a resistive leg
    always_comb begin
        bad_reg = 1'b0;
        for (int i = `SPECIAL_BASE; i < `PORT_PINS; i++) begin
            bad_reg = bad_reg | (pad_ctl[i].reg_lvl
                      & (pad_ctl[i].res_hi | pad_ctl[i].res_lo));
        end
    end

    // status bits not cleared last cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            keep_q <= '0;
        end else begin
            keep_q <= irq_status & ~irq_clr;
        end
    end

    // a taken write plus one more active cycle
    sequence wr_ok(s);
        (s && ce && phase == PH_RUN && !low_power) ##1 (ce && !low_power);
    endsequence

    pad_reset_a: assert property ($past(rst) |-> pad_ctl == '0
        && ref_ctl == '0) else $error("pads not idle after reset");
    nv_load_a: assert property (phase == PH_LOAD && ce
        && nv_rst_cfg != 2'b11 |=> phase == PH_RUN
        && rst_cfg == $past(nv_rst_cfg)) else $error("reset setting not loaded");
    sleep_hold_a: assert property (phase == PH_SLEEP
        && $past(phase) == PH_SLEEP |-> $stable(pad_ctl) && $stable(ref_ctl))
        else $error("pads moved in sleep");
    irq_wake_a: assert property (irq_req == (|irq_status)
        && wake_req == (irq_req && phase == PH_SLEEP))
        else $error("wake request wrong");
    irq_sticky_a: assert property (keep_q != '0
        |-> (irq_status & keep_q) == keep_q) else $error("status bit lost");
    reg_resist_a: assert property (!bad_reg)
        else $error("regulated pin with resistive drive");
    reg_level_a: assert property (wr_ok(cfg_wr[4])
        |=> pad_ctl[4].reg_lvl == $past(cfg_wdata.reg_out, 2))
        else $error("output level choice not applied");
    pair_ref_a: assert property (wr_ok(pair_wr[0])
        |=> ref_ctl[0].thr == $past(pair_wdata.thr, 2)
        && ref_ctl[0].use_analog == $past(pair_wdata.cmp_en, 2)
        && ref_ctl[0].hyst_en == $past(pair_wdata.hyst_en, 2))
        else $error("pair reference wrong");
    conn_gen_a: assert property (wr_ok(cfg_wr[1])
        |=> cfg_reject[1] == ($past(cfg_wdata.conn, 2) == 2'b11)
        && pad_ctl[1].conn != 2'b11) else $error("bus connection wrong");
    od_low_a: assert property (wr_ok(cfg_wr[0]
        && cfg_wdata.mode == DM_OD_LOW)
        |=> pad_ctl[0].strong_lo == !$past(cfg_wdata.data, 2)
        && !pad_ctl[0].strong_hi && !pad_ctl[0].res_hi
        && !pad_ctl[0].res_lo) else $error("open drain decode wrong");
endmodule

bind io_port_ctrl io_port_checker i_chk (.clk(clk), .rst(rst), .ce(ce),
    .nv_rst_cfg(nv_rst_cfg), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .pair_wr(pair_wr), .pair_wdata(pair_wdata), .low_power(low_power),
    .irq_clr(irq_clr), .irq_status(irq_status), .irq_req(irq_req),
    .wake_req(wake_req), .pad_ctl(pad_ctl), .ref_ctl(ref_ctl),
    .cfg_reject(cfg_reject), .rst_cfg(rst_cfg), .phase(phase));

// ==== pin_world.sv ====
// board model: resolves pad drive and external drivers into pin levels
`timescale 1ns/10ps
`include "io_port_map.svh"

module pin_world
    import io_port_pkg::*;
(
    // clock
    input wire logic                              clk,
    // pad drive from the block
    input io_port_pkg::pad_ctl_t [`PORT_PINS-1:0] pad_ctl,
    // board drivers commanded by the bench
    input wire logic [`PORT_PINS-1:0]             ext_en,
    input wire logic [`PORT_PINS-1:0]             ext_val,
    // resolved levels
    output logic [`PORT_PINS-1:0]                 pin_in
);
    logic [`PORT_PINS-1:0] float_q = 8'h55;

    // an undriven, unpulled pin wanders
    always_ff @(posedge clk) begin
        float_q <= ~float_q;
    end

    // strong drive wins, then the board, then the weak pulls
    always_comb begin
        for (int i = 0; i < `PORT_PINS; i++) begin
            if (pad_ctl[i].strong_hi || pad_ctl[i].strong_lo) begin
                pin_in[i] = pad_ctl[i].strong_hi;
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pad_ctl[i].res_hi || pad_ctl[i].res_lo) begin
                pin_in[i] = pad_ctl[i].res_hi;
            end else begin
                pin_in[i] = float_q[i];
            end
        end
    end
endmodule

// ==== tb.sv ====
// self-checking bench for the io port controller
`timescale 1ns/10ps
`include "io_port_map.svh"

module tb;
    import io_port_pkg::*;

    logic           clk = 1'b0, rst = 1'b1, ce = 1'b1;
    logic           rst_cfg_wr = 1'b0, low_power = 1'b0;
    rst_cfg_t       nv_rst_cfg = RST_PULL_UP, rst_cfg_wdata = RST_HIZ;
    logic [7:0]     cfg_wr = '0, irq_clr = '0, ext_en = '0, ext_val = '0;
    pin_cfg_t       cfg_wdata = '0;
    logic [1:0]     pair_wr = '0;
    pair_cfg_t      pair_wdata = '0;
    logic [7:0]     pin_in, irq_status, pin_data, cfg_reject;
    logic           irq_req, wake_req;
    pad_ctl_t [7:0] pad_ctl;
    ref_ctl_t [1:0] ref_ctl;
    rst_cfg_t       rst_cfg;
    phase_t         phase;
    int             num_errors = 0, comparisons = 0;

    always #10 clk = ~clk;

    io_port_ctrl i_dut (.clk(clk), .rst(rst), .ce(ce),
        .nv_rst_cfg(nv_rst_cfg), .rst_cfg_wr(rst_cfg_wr),
        .rst_cfg_wdata(rst_cfg_wdata), .cfg_wr(cfg_wr),
        .cfg_wdata(cfg_wdata), .pair_wr(pair_wr), .pair_wdata(pair_wdata),
        .low_power(low_power), .irq_clr(irq_clr), .irq_status(irq_status),
        .irq_req(irq_req), .wake_req(wake_req), .pin_in(pin_in),
        .pad_ctl(pad_ctl), .ref_ctl(ref_ctl), .pin_data(pin_data),
        .cfg_reject(cfg_reject), .rst_cfg(rst_cfg), .phase(phase));

    pin_world i_world (.clk(clk), .pad_ctl(pad_ctl), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(pin_in));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one strobe cycle, then wait for the pads
    task automatic wr(input logic [7:0] pm, input pin_cfg_t w,
                      input logic [1:0] qm, input pair_cfg_t q);
        @(posedge clk);
        cfg_wr <= pm;
        cfg_wdata <= w;
        pair_wr <= qm;
        pair_wdata <= q;
        @(posedge clk);
        cfg_wr <= '0;
        pair_wr <= '0;
        tick(1);
    endtask

    function automatic pin_cfg_t pc(input logic [2:0] m, input logic d,
                                    input logic [1:0] c, input logic ro,
                                    input logic [1:0] e);
        return pin_cfg_t'{drive_mode_t'(m), d, 1'b0, conn_t'(c), 3'h5, ro,
                          edge_t'(e)};
    endfunction

    // expected pad legs
    function automatic pad_ctl_t dec(input logic [2:0] m, input logic d);
        pad_ctl_t p;
        p = '0;
        p.in_en = (m != 3'h0);
        p.strong_hi = d && (m inside {3'h3, 3'h5, 3'h6});
        p.strong_lo = !d && (m inside {3'h2, 3'h4, 3'h6});
        p.res_hi = d && (m inside {3'h2, 3'h7});
        p.res_lo = !d && (m inside {3'h3, 3'h7});
        return p;
    endfunction

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        tick(11);
        check("pads in reset", pad_ctl == '0, 1);
        @(posedge clk);
        rst <= 1'b0;
        tick(1);
        check("phase", phase, PH_RUN);
        check("reset setting", rst_cfg, RST_PULL_UP);
        tick(1);
        check("pull up pads", pad_ctl == {8{dec(3'h7, 1'b1)}}, 1);
        @(posedge clk);
        rst_cfg_wr <= 1'b1;
        rst_cfg_wdata <= RST_PULL_DOWN;
        @(posedge clk);
        rst_cfg_wr <= 1'b0;
        tick(1);
        check("pull down pads", pad_ctl == {8{dec(3'h7, 1'b0)}}, 1);
        $display("test reset done");
    endtask

    task automatic t_modes();
        for (int m = 0; m < 8; m++) begin
            for (int d = 0; d < 2; d++) begin
                wr(8'h01, pc(m[2:0], d[0], 2'h0, 1'b0, 2'h0), 2'h0, '0);
                check("pin0 drive", pad_ctl[0], dec(m[2:0], d[0]));
            end
        end
        $display("test modes done");
    endtask

    task automatic t_special();
        pad_ctl_t e;
        logic     bad;
        for (int m = 2; m < 8; m++) begin
            bad = (m == 2 || m == 3 || m == 7);
            wr(8'h10, pc(m[2:0], 1'b1, 2'h0, 1'b1, 2'h0), 2'h0, '0);
            e = dec(bad ? 3'h1 : m[2:0], 1'b1);
            e.reg_lvl = 1'b1;
            check("pin4 regulated", pad_ctl[4], e);
            check("pin4 reject", cfg_reject[4], bad);
        end
        wr(8'h10, pc(3'h2, 1'b1, 2'h0, 1'b0, 2'h0), 2'h0, '0);
        check("pin4 supply level", pad_ctl[4], dec(3'h2, 1'b1));
        wr(8'h01, pc(3'h6, 1'b1, 2'h0, 1'b1, 2'h0), 2'h0, '0);
        check("pin0 no regulation", pad_ctl[0], dec(3'h6, 1'b1));
        $display("test special done");
    endtask

    task automatic t_pair();
        pair_cfg_t q;
        ref_ctl_t  e;
        for (int t = 0; t < 4; t++) begin
            q = '{thr_t'(t[1:0]), t[0], t[1], !t[0]};
            wr(8'h00, '0, 2'h1, q);
            e = '{t[0] | t[1], t[1], q.thr, !t[0]};
            check("pair0 ref", ref_ctl[0], e);
            check("pair1 ref", ref_ctl[1], '0);
        end
        $display("test pair done");
    endtask

    task automatic t_conn();
        pad_ctl_t e;
        for (int c = 1; c < 4; c++) begin
            wr(8'h22, pc(3'h0, 1'b0, c[1:0], 1'b0, 2'h0), 2'h0, '0);
            e = dec(3'h0, 1'b0);
            if (c < 3) begin
                e.conn = conn_t'(c[1:0]);
                e.bus_idx = 3'h5;
            end
            check("pin1 bus", pad_ctl[1], e);
            check("pin1 reject", cfg_reject[1], c == 3);
            check("pin5 no bus", pad_ctl[5], dec(3'h0, 1'b0));
        end
        $display("test conn done");
    endtask

    task automatic t_sleep();
        // board drives only general pin 3, never a special pin
        @(posedge clk);
        ext_en <= 8'h08;
        ext_val <= 8'h00;
        wr(8'h04, pc(3'h6, 1'b1, 2'h0, 1'b0, 2'h0), 2'h0, '0);
        wr(8'h08, pc(3'h1, 1'b0, 2'h0, 1'b0, EDGE_RISE), 2'h0, '0);
        @(posedge clk);
        low_power <= 1'b1;
        tick(2);
        check("phase sleep", phase, PH_SLEEP);
        wr(8'h04, pc(3'h6, 1'b0, 2'h0, 1'b0, 2'h0), 2'h0, '0);
        check("pin2 held", pad_ctl[2], dec(3'h6, 1'b1));
        @(posedge clk);
        ext_val <= 8'h08;
        tick(4);
        check("irq status", irq_status, 8'h08);
        check("wake", wake_req, 1'b1);
        check("irq req", irq_req, 1'b1);
        check("pin3 data", pin_data[3], 1'b1);
        @(posedge clk);
        irq_clr <= 8'h08;
        @(posedge clk);
        irq_clr <= '0;
        #1;
        check("irq cleared", irq_status, 8'h00);
        @(posedge clk);
        low_power <= 1'b0;
        tick(2);
        wr(8'h04, pc(3'h6, 1'b0, 2'h0, 1'b0, 2'h0), 2'h0, '0);
        check("pin2 after wake", pad_ctl[2], dec(3'h6, 1'b0));
        $display("test sleep done");
    endtask

    // ---------------------------------------------------------------
    // run and watchdog
    // ---------------------------------------------------------------
    initial begin
        t_reset();
        t_modes();
        t_special();
        t_pair();
        t_conn();
        t_sleep();
        conclude();
    end

    // tests take about 140 cycles
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        $display("Error watchdog expired");
        conclude();
    end
endmodule
